// >>> pkg/eee_mmd_pkg.sv
// Constants, field positions and decode for the EEE indirect register bank
`default_nettype none
package eee_mmd_pkg;
   // Management register indices used for indirect access
   localparam logic [4:0]  MII_MMD_CTRL   = 5'h0d;
   localparam logic [4:0]  MII_MMD_DATA   = 5'h0e;
   // Function field of the access control register
   localparam logic [1:0]  FN_ADDR        = 2'h0;
   localparam logic [1:0]  FN_DATA        = 2'h1;
   localparam logic [1:0]  FN_DATA_INC_RW = 2'h2;
   localparam logic [1:0]  FN_DATA_INC_WR = 2'h3;
   localparam int          CTRL_FN_HI     = 15;
   localparam int          CTRL_FN_LO     = 14;
   localparam int          CTRL_DEV_HI    = 4;
   localparam logic [8:0]  CTRL_PAD       = 9'h000;
   // Device numbers
   localparam logic [4:0]  DEV_PMA        = 5'h01;
   localparam logic [4:0]  DEV_PCS        = 5'h03;
   localparam logic [4:0]  DEV_AUTONEG    = 5'h07;
   // Register numbers inside each device
   localparam logic [15:0] ADR_PMA_STAT   = 16'h0001;
   localparam logic [15:0] ADR_TS_CAP     = 16'h0708;
   localparam logic [15:0] ADR_TX_MAX     = 16'h0709;
   localparam logic [15:0] ADR_TX_MIN     = 16'h070b;
   localparam logic [15:0] ADR_RX_MAX     = 16'h070d;
   localparam logic [15:0] ADR_RX_MIN     = 16'h070f;
   localparam logic [15:0] ADR_PCS_STAT   = 16'h0001;
   localparam logic [15:0] ADR_EEE_CAP    = 16'h0014;
   localparam logic [15:0] ADR_WAKE_CNT   = 16'h0016;
   localparam logic [15:0] ADR_ADV        = 16'h003c;
   localparam logic [15:0] ADR_LP_ADV     = 16'h003d;
   // Field positions
   localparam int          BIT_LINK       = 2;
   localparam int          BIT_TX_LPI_HIT = 11;
   localparam int          BIT_RX_LPI_HIT = 10;
   localparam int          BIT_TX_LPI_NOW = 9;
   localparam int          BIT_RX_LPI_NOW = 8;
   localparam int          BIT_EEE_1000   = 2;
   localparam int          BIT_EEE_100    = 1;
   localparam int          BIT_TS_TX      = 0;
   localparam logic [15:0] ADVERT_MASK    = 16'h0006;
   localparam logic [15:0] ZERO16         = 16'h0000;
   localparam logic [15:0] ADDR_STEP      = 16'h0001;
   // Latch kinds: bit set means latch high, clear means latch low
   localparam int          N_LATCH        = 4;
   localparam int          LT_PMA_LINK    = 0;
   localparam int          LT_PCS_LINK    = 1;
   localparam int          LT_TX_LPI      = 2;
   localparam int          LT_RX_LPI      = 3;
   localparam logic [3:0]  LATCH_HIGH_MAP = 4'hc;

   typedef enum logic [3:0] {
      SEL_NONE, SEL_PMA_STAT, SEL_TS_CAP, SEL_TX_MAX, SEL_TX_MIN, SEL_RX_MAX,
      SEL_RX_MIN, SEL_PCS_STAT, SEL_EEE_CAP, SEL_WAKE_CNT, SEL_ADV, SEL_LP_ADV
   } reg_sel_t;

   function automatic reg_sel_t decode_sel(input logic [4:0] dev, input logic [15:0] adr);
      reg_sel_t s;
      s = SEL_NONE;
      if (dev == DEV_PMA) begin
         if (adr == ADR_PMA_STAT) s = SEL_PMA_STAT;
         if (adr == ADR_TS_CAP) s = SEL_TS_CAP;
         if (adr == ADR_TX_MAX) s = SEL_TX_MAX;
         if (adr == ADR_TX_MIN) s = SEL_TX_MIN;
         if (adr == ADR_RX_MAX) s = SEL_RX_MAX;
         if (adr == ADR_RX_MIN) s = SEL_RX_MIN;
      end else if (dev == DEV_PCS) begin
         if (adr == ADR_PCS_STAT) s = SEL_PCS_STAT;
         if (adr == ADR_EEE_CAP) s = SEL_EEE_CAP;
         if (adr == ADR_WAKE_CNT) s = SEL_WAKE_CNT;
      end else if (dev == DEV_AUTONEG) begin
         if (adr == ADR_ADV) s = SEL_ADV;
         if (adr == ADR_LP_ADV) s = SEL_LP_ADV;
      end
      return s;
   endfunction
endpackage
`default_nettype wire

// >>> rtl/latch_status_bit.sv
// One latching status bit, latch-low or latch-high, re-armed by a read
`default_nettype none
module latch_status_bit #(
   parameter bit LATCH_HIGH = 1'b0
) (
   input  wire logic i_clk,
   input  wire logic i_srst,
   input  wire logic i_live,
   input  wire logic i_read_clr,
   output logic      o_latched
);
   logic event_hit;
   assign event_hit = LATCH_HIGH ? i_live : !i_live;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_latched <= 1'b0;
      end else if (i_read_clr) begin
         // Re-arm to the live value; an event in this cycle is kept
         o_latched <= i_live;
      end else if (event_hit) begin
         o_latched <= LATCH_HIGH;
      end
   end

   a_latch_holds: assert property (@(posedge i_clk) disable iff (i_srst)
      (event_hit && !i_read_clr) ##1 !i_read_clr[*3] |-> o_latched == LATCH_HIGH)
      else $error("latched status bit lost its event before a read");
endmodule
`default_nettype wire

// >>> rtl/wake_fault_counter.sv
// Saturating wake fault counter, cleared by a read or by reset
`default_nettype none
module wake_fault_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic             i_clk,
   input  wire logic             i_srst,
   input  wire logic             i_fault,
   input  wire logic             i_read_clr,
   output logic      [WIDTH-1:0] o_count
);
   localparam logic [WIDTH-1:0] CNT_ZERO = '0;
   localparam logic [WIDTH-1:0] CNT_ONE  = WIDTH'(1);
   localparam logic [WIDTH-1:0] CNT_MAX  = '1;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_count <= CNT_ZERO;
      end else if (i_read_clr) begin
         // A fault in the read cycle counts toward the next read
         o_count <= i_fault ? CNT_ONE : CNT_ZERO;
      end else if (i_fault && o_count != CNT_MAX) begin
         o_count <= o_count + CNT_ONE;
      end
   end

   a_count_steps: assert property (@(posedge i_clk) disable iff (i_srst)
      (i_fault && !i_read_clr && o_count != CNT_MAX) |=> o_count == $past(o_count) + CNT_ONE)
      else $error("wake fault not counted");
   a_count_clears: assert property (@(posedge i_clk) disable iff (i_srst)
      (i_read_clr && !i_fault) |=> o_count == CNT_ZERO)
      else $error("wake fault counter not cleared by read");
endmodule
`default_nettype wire

// >>> rtl/eee_mmd_regs.sv
// EEE and delay register bank reached through the indirect MMD registers
`default_nettype none
module eee_mmd_regs
   import eee_mmd_pkg::*;
#(
   parameter bit          EEE_1000_CAPABLE = 1'b1,
   parameter bit          EEE_100_CAPABLE  = 1'b1,
   parameter bit          TS_TX_CAPABLE    = 1'b1,
   parameter logic [15:0] TX_DELAY_MAX     = 16'h0000,
   parameter logic [15:0] TX_DELAY_MIN     = 16'h0000,
   parameter logic [15:0] RX_DELAY_MAX     = 16'h0000,
   parameter logic [15:0] RX_DELAY_MIN     = 16'h0000
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_soft_rst,
   input  wire logic [4:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   output logic             o_reg_ack,
   input  wire logic        i_link_up,
   input  wire logic        i_pma_link_up,
   input  wire logic        i_pcs_link_up,
   input  wire logic        i_tx_lpi,
   input  wire logic        i_rx_lpi,
   input  wire logic        i_wake_fault,
   input  wire logic        i_autoneg_done,
   input  wire logic [15:0] i_partner_advert,
   output logic      [15:0] o_local_advert
);
   logic             rst_any;
   logic [1:0]       ctrl_fn_r;
   logic [4:0]       ctrl_dev_r;
   logic [15:0]      mmd_addr_r;
   logic [15:0]      adv_r;
   logic [15:0]      link_partner_adv_r;
   logic [15:0]      wake_count;
   logic [15:0]      rd_val;
   logic [15:0]      rdata_nxt;
   logic             wr_any;
   logic             rd_any;
   logic             ctrl_wr;
   logic             addr_wr;
   logic             data_wr;
   logic             data_rd;
   logic             step_addr;
   logic             pma_stat_rd;
   logic             pcs_stat_rd;
   logic             wake_cnt_rd;
   reg_sel_t         sel;
   logic [N_LATCH-1:0] latch_live;
   logic [N_LATCH-1:0] latch_clr;
   logic [N_LATCH-1:0] latch_q;

   // Hardware and software reset clear the whole bank alike
   assign rst_any = i_srst | i_soft_rst;

   // A write wins over a read offered in the same cycle
   assign wr_any  = i_reg_wr;
   assign rd_any  = i_reg_rd & ~i_reg_wr;
   assign ctrl_wr = wr_any && i_reg_addr == MII_MMD_CTRL;
   assign addr_wr = wr_any && i_reg_addr == MII_MMD_DATA && ctrl_fn_r == FN_ADDR;
   assign data_wr = wr_any && i_reg_addr == MII_MMD_DATA && ctrl_fn_r != FN_ADDR;
   assign data_rd = rd_any && i_reg_addr == MII_MMD_DATA && ctrl_fn_r != FN_ADDR;
   assign step_addr = (ctrl_fn_r == FN_DATA_INC_RW && (data_wr || data_rd))
                    || (ctrl_fn_r == FN_DATA_INC_WR && data_wr);

   assign sel = decode_sel(ctrl_dev_r, mmd_addr_r);

   // Access control: function and device number
   always_ff @(posedge i_clk) begin
      if (rst_any) begin
         ctrl_fn_r  <= FN_ADDR;
         ctrl_dev_r <= DEV_PMA;
      end else if (ctrl_wr) begin
         ctrl_fn_r  <= i_reg_wdata[CTRL_FN_HI:CTRL_FN_LO];
         ctrl_dev_r <= i_reg_wdata[CTRL_DEV_HI:0];
      end
   end

   // Register number inside the selected device
   always_ff @(posedge i_clk) begin
      if (rst_any) begin
         mmd_addr_r <= ZERO16;
      end else if (addr_wr) begin
         mmd_addr_r <= i_reg_wdata;
      end else if (step_addr) begin
         mmd_addr_r <= mmd_addr_r + ADDR_STEP;
      end
   end

   // Local advertisement; only the two capability bits are stored
   always_ff @(posedge i_clk) begin
      if (rst_any) begin
         adv_r <= ZERO16;
      end else if (data_wr && sel == SEL_ADV) begin
         adv_r <= i_reg_wdata & ADVERT_MASK;
      end
   end
   assign o_local_advert = adv_r;

   // Partner advertisement follows autonegotiation only, never the bus
   always_ff @(posedge i_clk) begin
      if (rst_any) begin
         link_partner_adv_r <= ZERO16;
      end else if (i_autoneg_done) begin
         link_partner_adv_r <= i_partner_advert & ADVERT_MASK;
      end
   end

   // Latching status bits, re-armed to the live value by a read of their word
   assign latch_live[LT_PMA_LINK] = i_pma_link_up;
   assign latch_live[LT_PCS_LINK] = i_pcs_link_up;
   assign latch_live[LT_TX_LPI]   = i_tx_lpi;
   assign latch_live[LT_RX_LPI]   = i_rx_lpi;
   // Data reads that have side effects on latches or the counter
   assign pma_stat_rd = data_rd && sel == SEL_PMA_STAT;
   assign pcs_stat_rd = data_rd && sel == SEL_PCS_STAT;
   assign wake_cnt_rd = data_rd && sel == SEL_WAKE_CNT;
   assign latch_clr[LT_PMA_LINK]  = pma_stat_rd;
   assign latch_clr[LT_PCS_LINK]  = pcs_stat_rd;
   assign latch_clr[LT_TX_LPI]    = pcs_stat_rd;
   assign latch_clr[LT_RX_LPI]    = pcs_stat_rd;

   genvar gi;
   generate
      for (gi = 0; gi < N_LATCH; gi++) begin : g_latch
         latch_status_bit #(
            .LATCH_HIGH (LATCH_HIGH_MAP[gi])
         ) u_latch (
            .i_clk      (i_clk),
            .i_srst     (rst_any),
            .i_live     (latch_live[gi]),
            .i_read_clr (latch_clr[gi]),
            .o_latched  (latch_q[gi])
         );
      end
   endgenerate

   wake_fault_counter #(
      .WIDTH (16)
   ) u_wake_cnt (
      .i_clk      (i_clk),
      .i_srst     (rst_any),
      .i_fault    (i_wake_fault),
      .i_read_clr (wake_cnt_rd),
      .o_count    (wake_count)
   );

   // Read value of the selected register; unmapped reads give zero
   always_comb begin
      rd_val = ZERO16;
      unique case (sel)
         SEL_NONE: rd_val = ZERO16;
         SEL_PMA_STAT: rd_val[BIT_LINK] = latch_q[LT_PMA_LINK];
         SEL_TS_CAP: rd_val[BIT_TS_TX] = TS_TX_CAPABLE & i_link_up;
         SEL_TX_MAX: rd_val = i_link_up ? TX_DELAY_MAX : ZERO16;
         SEL_TX_MIN: rd_val = i_link_up ? TX_DELAY_MIN : ZERO16;
         SEL_RX_MAX: rd_val = i_link_up ? RX_DELAY_MAX : ZERO16;
         SEL_RX_MIN: rd_val = i_link_up ? RX_DELAY_MIN : ZERO16;
         SEL_PCS_STAT: begin
            rd_val[BIT_TX_LPI_HIT] = latch_q[LT_TX_LPI];
            rd_val[BIT_RX_LPI_HIT] = latch_q[LT_RX_LPI];
            rd_val[BIT_TX_LPI_NOW] = i_tx_lpi;
            rd_val[BIT_RX_LPI_NOW] = i_rx_lpi;
            rd_val[BIT_LINK]       = latch_q[LT_PCS_LINK];
         end
         SEL_EEE_CAP: begin
            rd_val[BIT_EEE_1000] = EEE_1000_CAPABLE;
            rd_val[BIT_EEE_100]  = EEE_100_CAPABLE;
         end
         SEL_WAKE_CNT: rd_val = wake_count;
         SEL_ADV: rd_val = adv_r;
         SEL_LP_ADV: rd_val = link_partner_adv_r;
      endcase
   end

   // Management read data: only registers 13 and 14 answer
   always_comb begin
      rdata_nxt = ZERO16;
      if (i_reg_addr == MII_MMD_CTRL) begin
         rdata_nxt = {ctrl_fn_r, CTRL_PAD, ctrl_dev_r};
      end else if (i_reg_addr == MII_MMD_DATA) begin
         rdata_nxt = (ctrl_fn_r == FN_ADDR) ? mmd_addr_r : rd_val;
      end
   end

   always_ff @(posedge i_clk) begin
      if (rst_any) begin
         o_reg_rdata <= ZERO16;
      end else if (rd_any) begin
         o_reg_rdata <= rdata_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (rst_any) begin
         o_reg_ack <= 1'b0;
      end else begin
         o_reg_ack <= rd_any | wr_any;
      end
   end

   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (rst_any);

   sequence s_addr_select;
      ctrl_fn_r == FN_ADDR && wr_any && i_reg_addr == MII_MMD_DATA;
   endsequence
   sequence s_data_mode;
      ctrl_wr && i_reg_wdata[CTRL_FN_HI:CTRL_FN_LO] != FN_ADDR;
   endsequence
   sequence s_bus_idle;
      !wr_any && !rd_any;
   endsequence

   // A station paces its accesses with two idle cycles between strobes
   a_addr_then_data: assert property (
      s_addr_select ##1 s_bus_idle[*2] ##1 s_data_mode |=> mmd_addr_r == $past(i_reg_wdata, 4)
         && ctrl_fn_r != FN_ADDR)
      else $error("indirect address not kept into data mode");
   a_ctrl_dev_load: assert property (
      ctrl_wr |=> ctrl_dev_r == $past(i_reg_wdata[CTRL_DEV_HI:0]))
      else $error("device number not taken from control write");
   a_post_increment: assert property (
      (data_rd && ctrl_fn_r == FN_DATA_INC_RW) |=> mmd_addr_r == $past(mmd_addr_r) + ADDR_STEP)
      else $error("address not stepped after data read");
   a_ack_follows: assert property ((rd_any || wr_any) |=> o_reg_ack)
      else $error("access not acknowledged one cycle later");
   a_delay_down_zero: assert property (
      (data_rd && !i_link_up && sel inside {SEL_TS_CAP, SEL_TX_MAX, SEL_TX_MIN,
         SEL_RX_MAX, SEL_RX_MIN}) |=> o_reg_rdata == ZERO16)
      else $error("delay word not zero while link down");
   a_lpi_live: assert property ((data_rd && sel == SEL_PCS_STAT) |=>
      o_reg_rdata[BIT_TX_LPI_NOW] == $past(i_tx_lpi)
      && o_reg_rdata[BIT_RX_LPI_NOW] == $past(i_rx_lpi))
      else $error("live LPI bits wrong");
   a_cap_value: assert property ((data_rd && sel == SEL_EEE_CAP) |=>
      o_reg_rdata == ({13'h0000, EEE_1000_CAPABLE, EEE_100_CAPABLE, 1'b0}))
      else $error("capability word wrong");
   a_adv_write: assert property ((data_wr && sel == SEL_ADV) |=>
      adv_r == ($past(i_reg_wdata) & ADVERT_MASK))
      else $error("advertisement write not stored");
   a_lp_read_only: assert property (
      (data_wr && sel == SEL_LP_ADV && !i_autoneg_done) |=> $stable(link_partner_adv_r))
      else $error("partner advertisement changed by a write");
   a_lp_capture: assert property (i_autoneg_done |=>
      link_partner_adv_r == ($past(i_partner_advert) & ADVERT_MASK))
      else $error("partner advertisement not captured");
   a_step_on_write: assert property (
      (data_wr && ctrl_fn_r == FN_DATA_INC_WR) |=> mmd_addr_r == $past(mmd_addr_r) + ADDR_STEP)
      else $error("address not stepped after data write");
   a_no_read_step: assert property (
      (data_rd && ctrl_fn_r != FN_DATA_INC_RW) |=> $stable(mmd_addr_r))
      else $error("address stepped by a read outside read-increment mode");
   a_ack_single: assert property ((!rd_any && !wr_any) |=> !o_reg_ack)
      else $error("acknowledge without an access");
   a_rdata_holds: assert property (!rd_any |=> $stable(o_reg_rdata))
      else $error("read data changed without a read");
   a_unmapped_idx: assert property (
      (rd_any && i_reg_addr != MII_MMD_CTRL && i_reg_addr != MII_MMD_DATA)
         |=> o_reg_rdata == ZERO16)
      else $error("unmapped management register not read as zero");
   a_ctrl_readback: assert property ((rd_any && i_reg_addr == MII_MMD_CTRL) |=>
      o_reg_rdata == {$past(ctrl_fn_r), CTRL_PAD, $past(ctrl_dev_r)})
      else $error("access control register read back wrong");
   a_addr_readback: assert property (
      (rd_any && i_reg_addr == MII_MMD_DATA && ctrl_fn_r == FN_ADDR)
         |=> o_reg_rdata == $past(mmd_addr_r))
      else $error("indirect address read back wrong");
   a_reserved_zero: assert property ((data_rd && sel == SEL_NONE) |=>
      o_reg_rdata == ZERO16)
      else $error("unmapped indirect address not read as zero");
   a_wake_readout: assert property (wake_cnt_rd |=>
      o_reg_rdata == $past(wake_count))
      else $error("wake fault count read wrong");
   a_pma_rearm: assert property (pma_stat_rd |=>
      latch_q[LT_PMA_LINK] == $past(i_pma_link_up))
      else $error("link latch not re-armed by read");
   a_link_drop: assert property (!i_pcs_link_up |=> !latch_q[LT_PCS_LINK])
      else $error("link drop not latched");
   a_tx_lpi_seen: assert property (i_tx_lpi |=> latch_q[LT_TX_LPI])
      else $error("transmit LPI not latched");
   a_rx_lpi_seen: assert property (i_rx_lpi |=> latch_q[LT_RX_LPI])
      else $error("receive LPI not latched");
endmodule
`default_nettype wire

// >>> testbench/mgmt_station.sv
// Station management model making indirect MMD accesses over registers 13 and 14
`default_nettype none
module mgmt_station
   import eee_mmd_pkg::*;
(
   input  wire logic        i_clk,
   output logic      [4:0]  o_reg_addr,
   output logic             o_reg_wr,
   output logic             o_reg_rd,
   output logic      [15:0] o_reg_wdata,
   input  wire logic [15:0] i_reg_rdata,
   input  wire logic        i_reg_ack
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_reg_addr = 5'h00;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_wdata = 16'h0000;
   end

   // One access; strobe is a single-cycle pulse, answer awaited for a few cycles
   task automatic acc(input logic wr, input logic [4:0] idx, input logic [15:0] d,
                      output logic [15:0] q);
      q = 'x;
      @(posedge i_clk);
      o_reg_addr  <= idx;
      o_reg_wr    <= wr;
      o_reg_rd    <= !wr;
      o_reg_wdata <= d;
      @(posedge i_clk);
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
      // Released data shows no stale value
      o_reg_wdata <= ~d;
      for (int n = 0; n < 4; n++) begin
         @(posedge i_clk);
         if (i_reg_ack === 1'b1) begin
            q = i_reg_rdata;
            break;
         end
      end
   endtask

   // Select device and register, then leave the given function in register 13
   task automatic point(input logic [1:0] fn, input logic [4:0] dev, input logic [15:0] adr);
      logic [15:0] q;
      acc(1'b1, MII_MMD_CTRL, {FN_ADDR, CTRL_PAD, dev}, q);
      acc(1'b1, MII_MMD_DATA, adr, q);
      acc(1'b1, MII_MMD_CTRL, {fn, CTRL_PAD, dev}, q);
   endtask
endmodule
`default_nettype wire

// >>> testbench/test_eee_mmd_regs.sv
// Self-checking bench for the EEE indirect register bank
`default_nettype none
module test_eee_mmd_regs
   import eee_mmd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [15:0] TX_MAX = 16'h0123;
   localparam logic [15:0] TX_MIN = 16'h0045;
   localparam logic [15:0] RX_MAX = 16'h0167;
   localparam logic [15:0] RX_MIN = 16'h0089;

   logic        clk, srst, soft_rst, link_up, pma_up, pcs_up;
   logic        tx_lpi, rx_lpi, wake, neg_done, wr, rd, ack;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, partner_adv, local_adv;
   logic [15:0] delays [8];
   int          error_cnt = 0;
   int          num_checks = 0;
   int          cyc = 0;

   eee_mmd_regs #(.TX_DELAY_MAX(TX_MAX), .TX_DELAY_MIN(TX_MIN),
                  .RX_DELAY_MAX(RX_MAX), .RX_DELAY_MIN(RX_MIN)) DUT (
      .i_clk(clk), .i_srst(srst), .i_soft_rst(soft_rst), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .o_reg_ack(ack), .i_link_up(link_up), .i_pma_link_up(pma_up),
      .i_pcs_link_up(pcs_up), .i_tx_lpi(tx_lpi), .i_rx_lpi(rx_lpi),
      .i_wake_fault(wake), .i_autoneg_done(neg_done),
      .i_partner_advert(partner_adv), .o_local_advert(local_adv));

   mgmt_station u_sta (
      .i_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
      .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_ack(ack));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_mmd(input logic [4:0] dev, input logic [15:0] adr,
                         output logic [15:0] q);
      u_sta.point(FN_DATA, dev, adr);
      u_sta.acc(1'b0, MII_MMD_DATA, ZERO16, q);
   endtask

   // Whole run needs a few hundred cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial begin
      logic [15:0] q;
      delays = '{16'h0001, TX_MAX, ZERO16, TX_MIN, ZERO16, RX_MAX, ZERO16, RX_MIN};
      srst = 1'b1;
      soft_rst = 1'b0;
      link_up = 1'b0;
      pma_up = 1'b1;
      pcs_up = 1'b1;
      tx_lpi = 1'b0;
      rx_lpi = 1'b0;
      wake = 1'b0;
      neg_done = 1'b0;
      partner_adv = 16'h0000;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      u_sta.acc(1'b0, MII_MMD_CTRL, ZERO16, q);
      check(q, {FN_ADDR, CTRL_PAD, DEV_PMA});
      u_sta.acc(1'b0, 5'h00, ZERO16, q);
      check(q, ZERO16);
      u_sta.point(FN_ADDR, DEV_PCS, ADR_WAKE_CNT);
      u_sta.acc(1'b0, MII_MMD_DATA, ZERO16, q);
      check(q, ADR_WAKE_CNT);
      rd_mmd(DEV_PCS, 16'h0002, q);
      check(q, ZERO16);
      // Delay words, link down then up, walked with post-increment
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) link_up <= k[0];
         u_sta.point(FN_DATA_INC_RW, DEV_PMA, ADR_TS_CAP);
         for (int i = 0; i < 8; i++) begin
            u_sta.acc(1'b0, MII_MMD_DATA, ZERO16, q);
            check(q, k == 1 ? delays[i] : ZERO16);
         end
      end
      // Latch-low PMA link: reset value, live value, a short drop
      rd_mmd(DEV_PMA, ADR_PMA_STAT, q);
      check(q, 16'h0000);
      rd_mmd(DEV_PMA, ADR_PMA_STAT, q);
      check(q, 16'h0004);
      @(posedge clk) pma_up <= 1'b0;
      @(posedge clk) pma_up <= 1'b1;
      rd_mmd(DEV_PMA, ADR_PMA_STAT, q);
      check(q, 16'h0000);
      rd_mmd(DEV_PMA, ADR_PMA_STAT, q);
      check(q, 16'h0004);
      // PCS status: latched and live LPI, latch-low link
      rd_mmd(DEV_PCS, ADR_PCS_STAT, q);
      check(q, 16'h0000);
      rd_mmd(DEV_PCS, ADR_PCS_STAT, q);
      check(q, 16'h0004);
      @(posedge clk) tx_lpi <= 1'b1;
      @(posedge clk) tx_lpi <= 1'b0;
      rx_lpi <= 1'b1;
      rd_mmd(DEV_PCS, ADR_PCS_STAT, q);
      check(q, 16'h0d04);
      @(posedge clk) begin
         rx_lpi <= 1'b0;
         tx_lpi <= 1'b1;
         pcs_up <= 1'b0;
      end
      @(posedge clk) pcs_up <= 1'b1;
      rd_mmd(DEV_PCS, ADR_PCS_STAT, q);
      check(q, 16'h0e00);
      @(posedge clk) tx_lpi <= 1'b0;
      rd_mmd(DEV_PCS, ADR_PCS_STAT, q);
      check(q, 16'h0804);
      rd_mmd(DEV_PCS, ADR_PCS_STAT, q);
      check(q, 16'h0004);
      rd_mmd(DEV_PCS, ADR_EEE_CAP, q);
      check(q, 16'h0006);
      // Wake faults counted, then cleared by the read
      repeat (3) begin
         @(posedge clk) wake <= 1'b1;
         @(posedge clk) wake <= 1'b0;
      end
      rd_mmd(DEV_PCS, ADR_WAKE_CNT, q);
      check(q, 16'h0003);
      rd_mmd(DEV_PCS, ADR_WAKE_CNT, q);
      check(q, 16'h0000);
      // Advertisements; write-increment mode steps onto the partner word
      rd_mmd(DEV_AUTONEG, ADR_ADV, q);
      check(q, 16'h0000);
      u_sta.point(FN_DATA_INC_WR, DEV_AUTONEG, ADR_ADV);
      u_sta.acc(1'b1, MII_MMD_DATA, 16'hffff, q);
      u_sta.acc(1'b1, MII_MMD_DATA, 16'hffff, q);
      // Reads in write-increment mode leave the address alone
      u_sta.acc(1'b0, MII_MMD_DATA, ZERO16, q);
      check(q, ZERO16);
      u_sta.acc(1'b1, MII_MMD_CTRL, {FN_ADDR, CTRL_PAD, DEV_AUTONEG}, q);
      u_sta.acc(1'b0, MII_MMD_DATA, ZERO16, q);
      check(q, 16'h003e);
      rd_mmd(DEV_AUTONEG, ADR_ADV, q);
      check(q, 16'h0006);
      check(local_adv, 16'h0006);
      rd_mmd(DEV_AUTONEG, ADR_LP_ADV, q);
      check(q, 16'h0000);
      @(posedge clk) begin
         partner_adv <= 16'hfff2;
         neg_done <= 1'b1;
      end
      @(posedge clk) neg_done <= 1'b0;
      rd_mmd(DEV_AUTONEG, ADR_LP_ADV, q);
      check(q, 16'h0002);
      // Software reset clears counter and advertisement
      repeat (2) begin
         @(posedge clk) wake <= 1'b1;
         @(posedge clk) wake <= 1'b0;
      end
      @(posedge clk) soft_rst <= 1'b1;
      @(posedge clk) soft_rst <= 1'b0;
      @(posedge clk);
      check(local_adv, 16'h0000);
      rd_mmd(DEV_PCS, ADR_WAKE_CNT, q);
      check(q, 16'h0000);
      report_and_stop();
   end
endmodule
`default_nettype wire
